// ==== design/rta_pkg.sv ====
package rta_pkg;
    // Relay count and channel variants
    localparam int NUM_RELAYS = 2;
    localparam int MAX_CHANNELS = 4;
    localparam int SRC_W = 2;

    // Relay cause codes
    typedef enum logic [1:0] {
        CAUSE_CLEAR = 2'b00,
        CAUSE_SENSOR_FAULT = 2'b01,
        CAUSE_OVER_TEMP = 2'b10,
        CAUSE_UNDER_TEMP = 2'b11
    } rta_cause_e;

    // Two-character status text, ASCII
    localparam logic [15:0] TEXT_CLEAR = 16'h2D2D;
    localparam logic [15:0] TEXT_SENSOR_FAULT = 16'h5346;
    localparam logic [15:0] TEXT_OVER_TEMP = 16'h4849;
    localparam logic [15:0] TEXT_UNDER_TEMP = 16'h4C4F;

    // Register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] RELAY_STRIDE = 8'h10;
    localparam logic [3:0] REG_CFG = 4'h0;
    localparam logic [3:0] REG_HIGH = 4'h4;
    localparam logic [3:0] REG_LOW = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hC;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h20;
    localparam logic [7:0] REG_IRQ_CLEAR = 8'h24;
    localparam logic [7:0] REG_IRQ_ENABLE = 8'h28;

    // Config and status field positions
    localparam int HIEN_BIT = 0;
    localparam int LOEN_BIT = 1;
    localparam int SRC_LSB = 4;
    localparam int TEXT_LSB = 16;

    // Interrupt bits: assert events low, clear events high
    localparam int IRQ_W = 2 * NUM_RELAYS;

    // Reset values
    localparam logic [31:0] SETPOINT_RST = 32'h00000000;
    localparam logic [SRC_W-1:0] SRC_RST = 2'h0;
    localparam logic ENABLE_RST = 1'b0;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h0;

    // Hysteresis band, fixed point with FRAC_BITS fraction bits
    localparam int FRAC_BITS = 12;
    localparam int HYST_MILLI_K = 250;
    localparam logic signed [31:0] HYST_FIX =
        32'(HYST_MILLI_K * (1 << FRAC_BITS) / 1000);

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== design/rta_relay_eval.sv ====
`timescale 1ns/1ps
module rta_relay_eval (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [31:0] tempIn,
    input wire logic sensorFault,
    input wire logic [31:0] highSetpoint,
    input wire logic [31:0] lowSetpoint,
    input wire logic highEnable,
    input wire logic lowEnable,
    output rta_pkg::rta_cause_e cause
);
    rta_pkg::rta_cause_e cause_ff;
    rta_pkg::rta_cause_e nxt_cause;
    logic signed [31:0] tFix;
    logic signed [31:0] hiFix;
    logic signed [31:0] loFix;
    logic overHi;
    logic underLo;

    // Float to signed fixed point, saturating
    function automatic logic signed [31:0] toFixed(input logic [31:0] f);
        logic [31:0] mag;
        logic [31:0] res;
        int sh;
        mag = {8'h00, 1'b1, f[22:0]};
        sh = int'(f[30:23]) - (127 + 23 - rta_pkg::FRAC_BITS);
        if (f[30:23] == 8'h00) begin
            res = 32'h00000000;
        end else if (sh > 7) begin
            res = 32'h7FFFFFFF;
        end else if (sh >= 0) begin
            res = mag << sh;
        end else if (sh > -24) begin
            res = mag >> (-sh);
        end else begin
            res = 32'h00000000;
        end
        return f[31] ? -$signed(res) : $signed(res);
    endfunction

    // Set points share the units of the filtered source temperature
    assign tFix = toFixed(tempIn);
    assign hiFix = toFixed(highSetpoint);
    assign loFix = toFixed(lowSetpoint);

    // Condition tests with hysteresis on release
    always_comb begin
        overHi = highEnable && (tFix > hiFix);
        underLo = lowEnable && (tFix < loFix);
        unique case (cause_ff)
            rta_pkg::CAUSE_OVER_TEMP: begin
                overHi = highEnable &&
                    (tFix > hiFix - rta_pkg::HYST_FIX);
            end
            rta_pkg::CAUSE_UNDER_TEMP: begin
                underLo = lowEnable &&
                    (tFix < loFix + rta_pkg::HYST_FIX);
            end
            rta_pkg::CAUSE_CLEAR, rta_pkg::CAUSE_SENSOR_FAULT: begin
            end
        endcase
        // Fault beats high beats low
        if (sensorFault) begin
            nxt_cause = rta_pkg::CAUSE_SENSOR_FAULT;
        end else if (overHi) begin
            nxt_cause = rta_pkg::CAUSE_OVER_TEMP;
        end else if (underLo) begin
            nxt_cause = rta_pkg::CAUSE_UNDER_TEMP;
        end else begin
            nxt_cause = rta_pkg::CAUSE_CLEAR;
        end
    end

    // Cause register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cause_ff <= rta_pkg::CAUSE_CLEAR;
        end else begin
            cause_ff <= nxt_cause;
        end
    end

    assign cause = cause_ff;

    chk_fault_first: assert property (
        @(posedge mclk) disable iff (!reset_n)
        sensorFault |=> cause_ff == rta_pkg::CAUSE_SENSOR_FAULT)
        else $error("sensor fault did not take the relay");
    chk_high_gate: assert property (
        @(posedge mclk) disable iff (!reset_n)
        !highEnable |=> cause_ff != rta_pkg::CAUSE_OVER_TEMP)
        else $error("high cause with high enable off");
    chk_low_gate: assert property (
        @(posedge mclk) disable iff (!reset_n)
        !lowEnable |=> cause_ff != rta_pkg::CAUSE_UNDER_TEMP)
        else $error("low cause with low enable off");
    chk_over_assert: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (!sensorFault && highEnable && tFix > hiFix)
        |=> cause_ff == rta_pkg::CAUSE_OVER_TEMP)
        else $error("over temperature not asserted");
    chk_under_assert: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (!sensorFault && !highEnable && lowEnable && tFix < loFix)
        |=> cause_ff == rta_pkg::CAUSE_UNDER_TEMP)
        else $error("under temperature not asserted");
    chk_hyst_hold: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (cause_ff == rta_pkg::CAUSE_OVER_TEMP && !sensorFault && highEnable
         && tFix > hiFix - rta_pkg::HYST_FIX)
        |=> cause_ff == rta_pkg::CAUSE_OVER_TEMP)
        else $error("over temperature released inside band");
    chk_hyst_release: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (cause_ff == rta_pkg::CAUSE_OVER_TEMP && !sensorFault && !lowEnable
         && tFix <= hiFix - rta_pkg::HYST_FIX)
        |=> cause_ff == rta_pkg::CAUSE_CLEAR)
        else $error("over temperature not released past band");
endmodule

// ==== design/rta_top.sv ====
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module rta_top #(
    parameter int NUM_CHANNELS = 4
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [NUM_CHANNELS-1:0][31:0] filteredTemp,
    input wire logic [NUM_CHANNELS-1:0] chanFault,
    input wire logic [rta_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [rta_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic [rta_pkg::NUM_RELAYS-1:0] relayOut,
    output logic irq
);
    localparam int NR = rta_pkg::NUM_RELAYS;
    localparam int IW = rta_pkg::IRQ_W;

    if (NUM_CHANNELS != 2 && NUM_CHANNELS != rta_pkg::MAX_CHANNELS) begin
        $error("NUM_CHANNELS must be 2 or 4");
    end

    // Bus state
    logic awHeld_ff, nxt_awHeld;
    logic [rta_pkg::ADDR_W-1:0] awAddr_ff, nxt_awAddr;
    logic wHeld_ff, nxt_wHeld;
    logic [31:0] wData_ff, nxt_wData;
    logic [3:0] wStrb_ff, nxt_wStrb;
    logic awReady_ff, nxt_awReady;
    logic wReady_ff, nxt_wReady;
    logic bValid_ff, nxt_bValid;
    logic [1:0] bResp_ff, nxt_bResp;
    logic arReady_ff, nxt_arReady;
    logic rValid_ff, nxt_rValid;
    logic [31:0] rData_ff, nxt_rData;
    logic [1:0] rResp_ff, nxt_rResp;
    logic doWrite;

    // Relay settings and state
    logic [NR-1:0][31:0] highSp_ff, nxt_highSp;
    logic [NR-1:0][31:0] lowSp_ff, nxt_lowSp;
    logic [NR-1:0] hiEn_ff, nxt_hiEn;
    logic [NR-1:0] loEn_ff, nxt_loEn;
    logic [NR-1:0][rta_pkg::SRC_W-1:0] src_ff, nxt_src;
    logic [NR-1:0] relay_ff, nxt_relay;
    logic [IW-1:0] irqStat_ff, nxt_irqStat;
    logic [IW-1:0] irqEn_ff, nxt_irqEn;
    logic irq_ff, nxt_irq;
    rta_pkg::rta_cause_e cause [NR];
    logic [NR-1:0] causeSet;

    // Byte-lane merge for partial writes
    function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Address is a relay register or an interrupt register
    function automatic logic isMapped(input logic [rta_pkg::ADDR_W-1:0] a);
        logic hit;
        hit = (a[7:4] < 4'(NR)) ||
            (a == rta_pkg::REG_IRQ_STATUS) ||
            (a == rta_pkg::REG_IRQ_CLEAR) ||
            (a == rta_pkg::REG_IRQ_ENABLE);
        return hit && (a[1:0] == 2'h0);
    endfunction

    // Status text for a cause code
    function automatic logic [15:0] causeText(input rta_pkg::rta_cause_e c);
        logic [15:0] t;
        t = rta_pkg::TEXT_CLEAR;
        unique case (c)
            rta_pkg::CAUSE_CLEAR: t = rta_pkg::TEXT_CLEAR;
            rta_pkg::CAUSE_SENSOR_FAULT: t = rta_pkg::TEXT_SENSOR_FAULT;
            rta_pkg::CAUSE_OVER_TEMP: t = rta_pkg::TEXT_OVER_TEMP;
            rta_pkg::CAUSE_UNDER_TEMP: t = rta_pkg::TEXT_UNDER_TEMP;
        endcase
        return t;
    endfunction

    // One evaluator per relay on its selected source
    for (genvar r = 0; r < NR; r++) begin : gRelay
        rta_relay_eval uEval (
            .mclk(mclk),
            .reset_n(reset_n),
            .tempIn(filteredTemp[src_ff[r]]),
            .sensorFault(chanFault[src_ff[r]]),
            .highSetpoint(highSp_ff[r]),
            .lowSetpoint(lowSp_ff[r]),
            .highEnable(hiEn_ff[r]),
            .lowEnable(loEn_ff[r]),
            .cause(cause[r])
        );
        assign causeSet[r] = cause[r] != rta_pkg::CAUSE_CLEAR;
    end

    // Write channel: address and data in either order
    always_comb begin
        nxt_awHeld = awHeld_ff;
        nxt_awAddr = awAddr_ff;
        nxt_wHeld = wHeld_ff;
        nxt_wData = wData_ff;
        nxt_wStrb = wStrb_ff;
        nxt_bValid = bValid_ff;
        nxt_bResp = bResp_ff;
        doWrite = 1'b0;
        if (awvalid && awReady_ff) begin
            nxt_awHeld = 1'b1;
            nxt_awAddr = awaddr;
        end
        if (wvalid && wReady_ff) begin
            nxt_wHeld = 1'b1;
            nxt_wData = wdata;
            nxt_wStrb = wstrb;
        end
        if (bValid_ff && bready) begin
            nxt_bValid = 1'b0;
        end
        if (awHeld_ff && wHeld_ff && !bValid_ff) begin
            doWrite = 1'b1;
            nxt_awHeld = 1'b0;
            nxt_wHeld = 1'b0;
            nxt_bValid = 1'b1;
            nxt_bResp = isMapped(awAddr_ff) ? rta_pkg::RESP_OKAY
                                            : rta_pkg::RESP_SLVERR;
        end
        nxt_awReady = !nxt_awHeld && !nxt_bValid;
        nxt_wReady = !nxt_wHeld && !nxt_bValid;
    end

    // Read channel: one cycle to data
    always_comb begin
        nxt_arReady = arReady_ff;
        nxt_rValid = rValid_ff;
        nxt_rData = rData_ff;
        nxt_rResp = rResp_ff;
        if (rValid_ff && rready) begin
            nxt_rValid = 1'b0;
        end
        if (arvalid && arReady_ff) begin
            nxt_rValid = 1'b1;
            nxt_rData = 32'h00000000;
            nxt_rResp = isMapped(araddr) ? rta_pkg::RESP_OKAY
                                         : rta_pkg::RESP_SLVERR;
            if (araddr == rta_pkg::REG_IRQ_STATUS) begin
                nxt_rData[IW-1:0] = irqStat_ff;
            end else if (araddr == rta_pkg::REG_IRQ_ENABLE) begin
                nxt_rData[IW-1:0] = irqEn_ff;
            end else if (araddr[7:4] < 4'(NR) && araddr[1:0] == 2'h0) begin
                unique case (araddr[3:0])
                    rta_pkg::REG_CFG: begin
                        nxt_rData[rta_pkg::HIEN_BIT] =
                            hiEn_ff[araddr[4]];
                        nxt_rData[rta_pkg::LOEN_BIT] = loEn_ff[araddr[4]];
                        nxt_rData[rta_pkg::SRC_LSB +: rta_pkg::SRC_W] =
                            src_ff[araddr[4]];
                    end
                    rta_pkg::REG_HIGH: nxt_rData = highSp_ff[araddr[4]];
                    rta_pkg::REG_LOW: nxt_rData = lowSp_ff[araddr[4]];
                    rta_pkg::REG_STATUS: begin
                        nxt_rData[1:0] = cause[araddr[4]];
                        nxt_rData[rta_pkg::TEXT_LSB +: 16] =
                            causeText(cause[araddr[4]]);
                    end
                    default: nxt_rData = 32'h00000000;
                endcase
            end
        end
        nxt_arReady = !nxt_rValid;
    end

    // Settings, relay pins and interrupts
    always_comb begin
        nxt_highSp = highSp_ff;
        nxt_lowSp = lowSp_ff;
        nxt_hiEn = hiEn_ff;
        nxt_loEn = loEn_ff;
        nxt_src = src_ff;
        nxt_irqEn = irqEn_ff;
        nxt_irqStat = irqStat_ff;
        if (doWrite && awAddr_ff[7:4] < 4'(NR) && awAddr_ff[1:0] == 2'h0) begin
            unique case (awAddr_ff[3:0])
                rta_pkg::REG_CFG: begin
                    if (wStrb_ff[0]) begin
                        nxt_hiEn[awAddr_ff[4]] =
                            wData_ff[rta_pkg::HIEN_BIT];
                        nxt_loEn[awAddr_ff[4]] =
                            wData_ff[rta_pkg::LOEN_BIT];
                        if (32'(wData_ff[rta_pkg::SRC_LSB +: rta_pkg::SRC_W])
                            < 32'(NUM_CHANNELS)) begin
                            nxt_src[awAddr_ff[4]] = wData_ff[
                                rta_pkg::SRC_LSB +: rta_pkg::SRC_W];
                        end
                    end
                end
                rta_pkg::REG_HIGH: nxt_highSp[awAddr_ff[4]] = laneMerge(
                    highSp_ff[awAddr_ff[4]], wData_ff, wStrb_ff);
                rta_pkg::REG_LOW: nxt_lowSp[awAddr_ff[4]] = laneMerge(
                    lowSp_ff[awAddr_ff[4]], wData_ff, wStrb_ff);
                default: begin
                end
            endcase
        end
        if (doWrite && awAddr_ff == rta_pkg::REG_IRQ_ENABLE
            && wStrb_ff[0]) begin
            nxt_irqEn = wData_ff[IW-1:0];
        end
        if (doWrite && awAddr_ff == rta_pkg::REG_IRQ_CLEAR
            && wStrb_ff[0]) begin
            nxt_irqStat = nxt_irqStat & ~wData_ff[IW-1:0];
        end
        // New events win over a clear in the same cycle
        nxt_irqStat = nxt_irqStat
            | {relay_ff & ~causeSet, causeSet & ~relay_ff};
        nxt_relay = causeSet;
        nxt_irq = |(nxt_irqStat & nxt_irqEn);
    end

    // State registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            awHeld_ff <= 1'b0;
            awAddr_ff <= '0;
            wHeld_ff <= 1'b0;
            wData_ff <= 32'h00000000;
            wStrb_ff <= 4'h0;
            awReady_ff <= 1'b0;
            wReady_ff <= 1'b0;
            bValid_ff <= 1'b0;
            bResp_ff <= rta_pkg::RESP_OKAY;
            arReady_ff <= 1'b0;
            rValid_ff <= 1'b0;
            rData_ff <= 32'h00000000;
            rResp_ff <= rta_pkg::RESP_OKAY;
            highSp_ff <= {NR{rta_pkg::SETPOINT_RST}};
            lowSp_ff <= {NR{rta_pkg::SETPOINT_RST}};
            hiEn_ff <= {NR{rta_pkg::ENABLE_RST}};
            loEn_ff <= {NR{rta_pkg::ENABLE_RST}};
            src_ff <= {NR{rta_pkg::SRC_RST}};
            relay_ff <= '0;
            irqStat_ff <= '0;
            irqEn_ff <= rta_pkg::IRQ_EN_RST;
            irq_ff <= 1'b0;
        end else begin
            awHeld_ff <= nxt_awHeld;
            awAddr_ff <= nxt_awAddr;
            wHeld_ff <= nxt_wHeld;
            wData_ff <= nxt_wData;
            wStrb_ff <= nxt_wStrb;
            awReady_ff <= nxt_awReady;
            wReady_ff <= nxt_wReady;
            bValid_ff <= nxt_bValid;
            bResp_ff <= nxt_bResp;
            arReady_ff <= nxt_arReady;
            rValid_ff <= nxt_rValid;
            rData_ff <= nxt_rData;
            rResp_ff <= nxt_rResp;
            highSp_ff <= nxt_highSp;
            lowSp_ff <= nxt_lowSp;
            hiEn_ff <= nxt_hiEn;
            loEn_ff <= nxt_loEn;
            src_ff <= nxt_src;
            relay_ff <= nxt_relay;
            irqStat_ff <= nxt_irqStat;
            irqEn_ff <= nxt_irqEn;
            irq_ff <= nxt_irq;
        end
    end

    // Output drive
    assign awready = awReady_ff;
    assign wready = wReady_ff;
    assign bvalid = bValid_ff;
    assign bresp = bResp_ff;
    assign arready = arReady_ff;
    assign rvalid = rValid_ff;
    assign rdata = rData_ff;
    assign rresp = rResp_ff;
    assign relayOut = relay_ff;
    assign irq = irq_ff;

    chk_relay_pin: assert property (
        @(posedge mclk) disable iff (!reset_n)
        relay_ff == $past(causeSet))
        else $error("relay pins do not follow the causes");
    chk_setpoint_store: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (doWrite && awAddr_ff == rta_pkg::REG_HIGH && wStrb_ff == 4'hF)
        |=> highSp_ff[0] == $past(wData_ff))
        else $error("high set point not stored whole");
    chk_irq_level: assert property (@(posedge mclk) disable iff (!reset_n)
        ##1 irq_ff == |(irqStat_ff & irqEn_ff))
        else $error("interrupt level wrong");
endmodule

// ==== testbench/rta_host.sv ====
`timescale 1ns/1ps
// Host controller model: AXI4-Lite master for settings and queries
module rta_host (
    input wire logic mclk,
    output logic [rta_pkg::ADDR_W-1:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [rta_pkg::ADDR_W-1:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // Idle bus at time zero
    initial begin
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b0;
    end

    // Write: both channels offered, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (awready && !awDone) begin
                awDone = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !wDone) begin
                wDone = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    // Read: address held until taken, data taken with rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (arready && arvalid) begin
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask
endmodule

// ==== testbench/relay_threshold_alarm_tb.sv ====
`timescale 1ns/1ps
module relay_threshold_alarm_tb;
    logic mclk;
    logic reset_n;
    logic [3:0][31:0] filteredTemp;
    logic [3:0] chanFault;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, relayOut;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    int nMismatch = 0;
    int testsRun = 0;
    int cycles = 0;

    rta_top #(.NUM_CHANNELS(4)) dut (.mclk(mclk), .reset_n(reset_n),
        .filteredTemp(filteredTemp), .chanFault(chanFault),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .relayOut(relayOut), .irq(irq));

    rta_host host (.mclk(mclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    // Clock and run-length guard
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            nMismatch++;
            endSim();
        end
    end

    task automatic endSim();
        if (nMismatch == 0 && testsRun > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nMismatch++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wrOk(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        host.wr(a, d, r);
        chk("bresp", {30'h0, r}, 32'h0);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        host.rd(a, d, r);
        chk("rdata", d, exp);
        chk("rresp", {30'h0, r}, 32'h0);
    endtask

    // New channel temperature, then settle cause, relay and irq
    task automatic setT(input int ch, input logic [31:0] v);
        @(posedge mclk);
        filteredTemp[ch] <= v;
        repeat (4) @(posedge mclk);
    endtask

    // Status word and relay contact of one relay
    task automatic st(input int r, input rta_pkg::rta_cause_e c,
                      input logic [15:0] t);
        rdChk(8'(r * 16 + 12), {t, 14'h0, 2'(c)});
        chk("relayOut", {31'h0, relayOut[r]},
            {31'h0, c != rta_pkg::CAUSE_CLEAR});
    endtask

    task automatic tReset();
        logic [1:0] r;
        logic [31:0] d;
        rdChk(8'h10, 32'h0);
        rdChk(8'h14, 32'h0);
        rdChk(8'h1C, {rta_pkg::TEXT_CLEAR, 16'h0});
        rdChk(8'h28, 32'h0);
        wrOk(8'h10, 32'h33);
        rdChk(8'h10, 32'h33);
        wrOk(8'h14, 32'h42C84000);
        rdChk(8'h14, 32'h42C84000);
        host.rd(8'h30, d, r);
        chk("unmapped", d, 32'h0);
        chk("slverr", {30'h0, r}, {30'h0, rta_pkg::RESP_SLVERR});
    endtask

    task automatic tHigh();
        wrOk(8'h00, 32'h21);
        wrOk(8'h04, 32'h42C80000);
        wrOk(8'h24, 32'hF);
        wrOk(8'h28, 32'h1);
        setT(0, 32'h43480000);
        st(0, rta_pkg::CAUSE_CLEAR, rta_pkg::TEXT_CLEAR);
        setT(2, 32'h42C80000);
        st(0, rta_pkg::CAUSE_CLEAR, rta_pkg::TEXT_CLEAR);
        setT(2, 32'h42C84000);
        st(0, rta_pkg::CAUSE_OVER_TEMP, rta_pkg::TEXT_OVER_TEMP);
        chk("irq", {31'h0, irq}, 32'h1);
        wrOk(8'h24, 32'h1);
        repeat (2) @(posedge mclk);
        chk("irq", {31'h0, irq}, 32'h0);
        setT(2, 32'h42C7C000);
        st(0, rta_pkg::CAUSE_OVER_TEMP, rta_pkg::TEXT_OVER_TEMP);
        wrOk(8'h28, 32'h4);
        setT(2, 32'h42C78000);
        st(0, rta_pkg::CAUSE_CLEAR, rta_pkg::TEXT_CLEAR);
        chk("irq", {31'h0, irq}, 32'h1);
        wrOk(8'h28, 32'h0);
        repeat (2) @(posedge mclk);
        chk("irq", {31'h0, irq}, 32'h0);
        rdChk(8'h20, 32'h4);
        wrOk(8'h24, 32'h4);
        rdChk(8'h20, 32'h0);
    endtask

    task automatic tLow();
        wrOk(8'h00, 32'h22);
        wrOk(8'h08, 32'h42480000);
        setT(2, 32'h43480000);
        st(0, rta_pkg::CAUSE_CLEAR, rta_pkg::TEXT_CLEAR);
        setT(2, 32'h42440000);
        st(0, rta_pkg::CAUSE_UNDER_TEMP, rta_pkg::TEXT_UNDER_TEMP);
        setT(2, 32'h42488000);
        st(0, rta_pkg::CAUSE_UNDER_TEMP, rta_pkg::TEXT_UNDER_TEMP);
        setT(2, 32'h42490000);
        st(0, rta_pkg::CAUSE_CLEAR, rta_pkg::TEXT_CLEAR);
    endtask

    task automatic tFault();
        wrOk(8'h00, 32'h23);
        wrOk(8'h10, 32'h32);
        wrOk(8'h18, 32'h42480000);
        setT(2, 32'h43480000);
        setT(3, 32'h42440000);
        st(1, rta_pkg::CAUSE_UNDER_TEMP, rta_pkg::TEXT_UNDER_TEMP);
        st(0, rta_pkg::CAUSE_OVER_TEMP, rta_pkg::TEXT_OVER_TEMP);
        chanFault[2] <= 1'b1;
        repeat (4) @(posedge mclk);
        st(0, rta_pkg::CAUSE_SENSOR_FAULT,
            rta_pkg::TEXT_SENSOR_FAULT);
        st(1, rta_pkg::CAUSE_UNDER_TEMP, rta_pkg::TEXT_UNDER_TEMP);
    endtask

    // Reset in mid-run drops relays and settings
    task automatic tMidReset();
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("relayOut", {30'h0, relayOut}, 32'h0);
        reset_n <= 1'b1;
        repeat (2) @(posedge mclk);
        rdChk(8'h00, 32'h0);
        st(0, rta_pkg::CAUSE_CLEAR, rta_pkg::TEXT_CLEAR);
    endtask

    // Reset, scenarios, verdict
    initial begin
        reset_n = 1'b0;
        filteredTemp = '0;
        chanFault = 4'h0;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (2) @(posedge mclk);
        tReset();
        tHigh();
        tLow();
        tFault();
        tMidReset();
        endSim();
    end
endmodule
